// >>> core/pfcr_regs.svh
// constants of the fan curve and acoustic ramp block
// assumes inclusion by the design modules, by bare name
// How it works
// - the 8-bit start threshold resets to E0 (-32); above it duty is at least minimum.
// - above the threshold duty climbs from minimum along the slope as temperature rises.
// - while the global lock is set, writes to the start threshold are ignored.
// - the span and ramp register resets to C0 and rejects writes once the lock is set.
// - the 3-bit ramp field in bits 2..0 makes duty step gradually toward its target.
// - frequency select 0: ramp codes give steps 1,2,3,4,8,12,24,48 (37.5 s to 0.8 s).
// - frequency select 1: the same codes give full-scale times of 52.2 s to 1.1 s.
// - ramp steps follow a round-robin cycle of about 165 ms, scaled by the refresh period.
// - bit 3 enables smoothing; when clear, duty changes are not rate limited.
// - span field bits 7..4 select 2 to 80 degrees; code C (32 degrees) is the reset.
// - the lock is set once and keeps lockable registers read-only until power is cycled.
// - reset loads full scale (FF) into duty; from the first edge after release, duty is capped at the maximum duty input.
`ifndef PFCR_REGS_SVH
`define PFCR_REGS_SVH

// register offsets
`define PFCR_ADDR_START_THRESHOLD 8'h3B
`define PFCR_ADDR_SPAN_RAMP       8'h3C
// reset values
`define PFCR_RST_START_THRESHOLD  8'hE0
`define PFCR_RST_SPAN_RAMP        8'hC0
`define PFCR_RST_MAX_DUTY         8'hFF
// field positions of the span and ramp register
`define PFCR_RAMP_MSB             2
`define PFCR_RAMP_LSB             0
`define PFCR_SMOOTH_BIT           3
`define PFCR_SPAN_MSB             7
`define PFCR_SPAN_LSB             4
// timing: round-robin cycle, and the slower cycle with frequency select set
`define PFCR_CLK_MHZ              100
`define PFCR_RR_CYCLE_MS          165
`define PFCR_RR_SLOW_NUM          522
`define PFCR_RR_SLOW_DEN          375
`define PFCR_RR_CYCLES            (`PFCR_RR_CYCLE_MS * 1000 * `PFCR_CLK_MHZ)
// divide first so the 32-bit constant arithmetic cannot overflow
`define PFCR_RR_SLOW_CYCLES       ((`PFCR_RR_CYCLES / `PFCR_RR_SLOW_DEN) * `PFCR_RR_SLOW_NUM)
// slope scaling: gain is 4096 divided by the span in degrees
`define PFCR_GAIN_SHIFT           12

`endif

// >>> core/pfcr_pkg.sv
// types shared by the fan curve and ramp modules
// assumes nothing outside itself
package pfcr_pkg;
    typedef logic [7:0]  pfcr_byte_t;
    typedef logic [31:0] pfcr_count_t;

    // state of the ramp datapath
    typedef struct packed {
        pfcr_byte_t  start_threshold;
        pfcr_byte_t  span_ramp;
        pfcr_byte_t  duty;
        pfcr_byte_t  rdata;
        pfcr_count_t rr_count;
        logic        reading_pending;
    } pfcr_state_t;
endpackage

// >>> core/pfcr_duty_calc.sv
// target duty from temperature, start threshold and span
// assumes all inputs are stable on the core clock; purely combinational
`timescale 1ns/1ps
`include "pfcr_regs.svh"
module pfcr_duty_calc (
    input  wire logic [7:0] i_peci_temp,
    input  wire logic [7:0] i_fan_start_threshold,
    input  wire logic [3:0] i_temperature_span,
    input  wire logic [7:0] i_minimum_duty,
    input  wire logic [7:0] i_max_duty,
    output logic      [7:0] o_target_duty
);
    // gain of 4096 divided by the span in degrees, codes in ascending span order
    function automatic logic [11:0] span_gain(input logic [3:0] code);
        unique case (code)
            4'h0: span_gain = 12'h800; // 2
            4'h1: span_gain = 12'h666; // 2.5
            4'h2: span_gain = 12'h4CD; // 3.33
            4'h3: span_gain = 12'h400; // 4
            4'h4: span_gain = 12'h333; // 5
            4'h5: span_gain = 12'h266; // 6.67
            4'h6: span_gain = 12'h200; // 8
            4'h7: span_gain = 12'h19A; // 10
            4'h8: span_gain = 12'h133; // 13.33
            4'h9: span_gain = 12'h100; // 16
            4'hA: span_gain = 12'h0CD; // 20
            4'hB: span_gain = 12'h09A; // 26.67
            4'hC: span_gain = 12'h080; // 32
            4'hD: span_gain = 12'h066; // 40
            4'hE: span_gain = 12'h04D; // 53.33
            4'hF: span_gain = 12'h033; // 80
        endcase
    endfunction

    logic signed [8:0] delta;
    logic        [7:0] headroom;
    logic       [28:0] rise;
    logic        [8:0] raw;
    logic        [7:0] curve;

    // signed distance above the threshold, and linear rise across the span
    always_comb begin
        delta    = $signed({i_peci_temp[7], i_peci_temp})
                 - $signed({i_fan_start_threshold[7], i_fan_start_threshold});
        headroom = 8'hFF - i_minimum_duty;
        raw      = 9'h000; // no latch on the saturating paths
        rise     = 29'(headroom) * 29'(delta[7:0]) * 29'(span_gain(i_temperature_span));
        if (delta <= 9'sh000) begin
            curve = i_minimum_duty;
        end else if (rise[28:`PFCR_GAIN_SHIFT] >= 17'(headroom)) begin
            curve = 8'hFF;
        end else begin
            raw   = 9'(i_minimum_duty) + 9'(rise[`PFCR_GAIN_SHIFT+7:`PFCR_GAIN_SHIFT]);
            curve = raw[8] ? 8'hFF : raw[7:0];
        end
        o_target_duty = (curve > i_max_duty) ? i_max_duty : curve;
    end
endmodule

// >>> core/pfcr_top.sv
// start threshold and span/ramp registers with the ramped fan duty output
// assumes register strobes, lock, reading and fan settings come from core-clock logic
`timescale 1ns/1ps
`include "pfcr_regs.svh"
module pfcr_top #(
    parameter logic [31:0] P_RR_CYCLES      = `PFCR_RR_CYCLES,
    parameter logic [31:0] P_RR_SLOW_CYCLES = `PFCR_RR_SLOW_CYCLES
) (
    input  wire logic       i_core_clk,
    input  wire logic       i_rstn,
    input  wire logic       i_reg_wr,
    input  wire logic [7:0] i_reg_addr,
    input  wire logic [7:0] i_reg_wdata,
    input  wire logic       i_global_lock,
    input  wire logic       i_pwm_freq_sel,
    input  wire logic [7:0] i_peci_temp,
    input  wire logic       i_peci_valid,
    input  wire logic [7:0] i_minimum_duty,
    input  wire logic [7:0] i_max_duty,
    output logic      [7:0] o_reg_rdata,
    output logic      [7:0] o_duty
);
    // step size per round-robin cycle for each ramp code
    function automatic logic [7:0] ramp_step(input logic [2:0] code);
        unique case (code)
            3'h0: ramp_step = 8'h01;
            3'h1: ramp_step = 8'h02;
            3'h2: ramp_step = 8'h03;
            3'h3: ramp_step = 8'h04;
            3'h4: ramp_step = 8'h08;
            3'h5: ramp_step = 8'h0C;
            3'h6: ramp_step = 8'h18;
            3'h7: ramp_step = 8'h30;
        endcase
    endfunction

    pfcr_pkg::pfcr_state_t s_q;
    pfcr_pkg::pfcr_state_t s_d;
    logic [7:0]  target;
    logic [7:0]  step;
    logic [31:0] rr_period;
    logic        rr_tick;
    logic        wr_ok;

    pfcr_duty_calc u_calc (
        .i_peci_temp           (i_peci_temp),
        .i_fan_start_threshold (s_q.start_threshold),
        .i_temperature_span    (s_q.span_ramp[`PFCR_SPAN_MSB:`PFCR_SPAN_LSB]),
        .i_minimum_duty        (i_minimum_duty),
        .i_max_duty            (i_max_duty),
        .o_target_duty         (target)
    );

    // next-state logic: registers, round-robin divider, ramp
    always_comb begin
        s_d       = s_q;
        wr_ok     = i_reg_wr && !i_global_lock;
        step      = ramp_step(s_q.span_ramp[`PFCR_RAMP_MSB:`PFCR_RAMP_LSB]);
        rr_period = i_pwm_freq_sel ? P_RR_SLOW_CYCLES : P_RR_CYCLES;
        rr_tick   = (s_q.rr_count >= rr_period - 32'h1);

        // lock-guarded register writes
        if (wr_ok && i_reg_addr == `PFCR_ADDR_START_THRESHOLD) begin
            s_d.start_threshold = i_reg_wdata;
        end
        if (wr_ok && i_reg_addr == `PFCR_ADDR_SPAN_RAMP) begin
            s_d.span_ramp = i_reg_wdata;
        end

        // registered read of the addressed register
        unique case (i_reg_addr)
            `PFCR_ADDR_START_THRESHOLD: s_d.rdata = s_q.start_threshold;
            `PFCR_ADDR_SPAN_RAMP:       s_d.rdata = s_q.span_ramp;
            default:                    s_d.rdata = 8'h00;
        endcase

        // round-robin divider
        s_d.rr_count = rr_tick ? 32'h0 : s_q.rr_count + 32'h1;

        // a reading arriving on the tick is kept for the next cycle
        if (rr_tick) begin
            s_d.reading_pending = i_peci_valid;
        end else if (i_peci_valid) begin
            s_d.reading_pending = 1'b1;
        end

        // duty: immediate without smoothing, stepped per cycle with it
        if (!s_q.span_ramp[`PFCR_SMOOTH_BIT]) begin
            if (i_peci_valid) begin
                s_d.duty = target;
            end
        end else if (rr_tick && s_q.reading_pending) begin
            if (target > s_q.duty) begin
                s_d.duty = (target - s_q.duty > step) ? s_q.duty + step : target;
            end else begin
                s_d.duty = (s_q.duty - target > step) ? s_q.duty - step : target;
            end
        end
        if (s_d.duty > i_max_duty) begin
            s_d.duty = i_max_duty;
        end
    end

    // state register with synchronous reset
    always_ff @(posedge i_core_clk) begin
        if (!i_rstn) begin
            s_q.start_threshold <= `PFCR_RST_START_THRESHOLD;
            s_q.span_ramp       <= `PFCR_RST_SPAN_RAMP;
            s_q.duty            <= `PFCR_RST_MAX_DUTY;
            s_q.rdata           <= 8'h00;
            s_q.rr_count        <= 32'h0;
            s_q.reading_pending <= 1'b0;
        end else begin
            s_q <= s_d;
        end
    end

    assign o_reg_rdata = s_q.rdata;
    assign o_duty      = s_q.duty;
endmodule

// >>> testbench/pfcr_props.sv
// port assertions for the fan curve and ramp block
// assumes one core clock and a synchronous active-low reset
`timescale 1ns/1ps
module pfcr_props (
    input wire logic       i_core_clk,
    input wire logic       i_rstn,
    input wire logic       i_reg_wr,
    input wire logic [7:0] i_reg_addr,
    input wire logic [7:0] i_reg_wdata,
    input wire logic       i_global_lock,
    input wire logic       i_peci_valid,
    input wire logic [7:0] i_max_duty,
    input wire logic [7:0] o_reg_rdata,
    input wire logic [7:0] o_duty
);
    logic [7:0] sr_q;
    logic       map;
    int         st[8] = '{1, 2, 3, 4, 8, 12, 24, 48};
    assign map = i_reg_addr == 8'h3B || i_reg_addr == 8'h3C;
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (!i_rstn);
    // shadow of the span and ramp register
    always_ff @(posedge i_core_clk) begin
        if (!i_rstn) sr_q <= 8'hC0;
        else if (i_reg_wr && !i_global_lock && i_reg_addr == 8'h3C) sr_q <= i_reg_wdata;
    end
    rst_span_a: assert property (!$past(i_rstn) && i_reg_addr == 8'h3C |=>
        o_reg_rdata == 8'hC0) else $error("span register reset value wrong");
    lock_hold_a: assert property (i_reg_wr && i_global_lock && map ##1 $stable(i_reg_addr)
        |=> o_reg_rdata == $past(o_reg_rdata)) else $error("locked write took effect");
    wr_take_a: assert property (i_reg_wr && !i_global_lock && map ##1 $stable(i_reg_addr)
        |=> o_reg_rdata == $past(i_reg_wdata, 2)) else $error("write not taken");
    rd_span_a: assert property (i_reg_addr == 8'h3C |=> o_reg_rdata == $past(sr_q))
        else $error("span register read wrong");
    unmap_rd_a: assert property (!map |=> o_reg_rdata == 8'h00) else $error("unmapped read");
    max_cap_a: assert property (i_rstn |=> o_duty <= $past(i_max_duty))
        else $error("duty above maximum");
    duty_hold_a: assert property (!sr_q[3] && !i_peci_valid && $stable(i_max_duty)
        && $past(i_rstn) |=> $stable(o_duty)) else $error("duty moved without a reading");
    // the step is bounded by the code that stood at the updating edge
    ramp_step_a: assert property (sr_q[3] && $stable(i_max_duty) |=>
        (o_duty > $past(o_duty) ? o_duty - $past(o_duty) : $past(o_duty) - o_duty)
        <= st[$past(sr_q[2:0])]) else $error("duty step too large");
    smooth_c: cover property (i_peci_valid && sr_q[3]);
    direct_c: cover property (i_peci_valid && !sr_q[3]);
    locked_c: cover property (i_reg_wr && i_global_lock);
endmodule
bind pfcr_top pfcr_props u_props (.i_core_clk, .i_rstn, .i_reg_wr, .i_reg_addr, .i_reg_wdata,
    .i_global_lock, .i_peci_valid, .i_max_duty, .o_reg_rdata, .o_duty);

// >>> testbench/pfcr_peci_src.sv
// far-side model: source of temperature readings
// assumes the block's core clock; readings launch at the falling edge
`timescale 1ns/1ps
module pfcr_peci_src (
    input  wire logic       i_core_clk,
    output logic      [7:0] o_peci_temp = 8'h00,
    output logic            o_peci_valid = 1'b0
);
    // one reading: level held, valid for one cycle
    task automatic send(input logic [7:0] t);
        @(negedge i_core_clk);
        o_peci_temp = t;
        o_peci_valid = 1'b1;
        @(negedge i_core_clk);
        o_peci_valid = 1'b0;
    endtask
endmodule

// >>> testbench/peci_fan_curve_and_ramp_test.sv
// self-checking bench for the fan curve and ramp block
// assumes pfcr_top, the reading source and the bound checker
`timescale 1ns/1ps
module peci_fan_curve_and_ramp_test;
    logic       clk = 0, rstn = 0, wr = 0, lock = 0, fsel = 0;
    logic [7:0] addr = 0, wdata = 0, mind = 0, maxd = 8'hFF, rnd = 8'h5B, thr, tmp, rdata, duty;
    wire  [7:0] ptemp;
    wire        pval;
    int         error_cnt = 0, cmp_count = 0, n;
    int         gn[16] = '{2048, 1638, 1229, 1024, 819, 614, 512, 410, 307, 256, 205, 154,
                           128, 102, 77, 51};
    always #5 clk = ~clk;
    pfcr_peci_src u_peci (.i_core_clk(clk), .o_peci_temp(ptemp), .o_peci_valid(pval));
    pfcr_top #(.P_RR_CYCLES(32'h14), .P_RR_SLOW_CYCLES(32'h1C)) u_dut (.i_core_clk(clk),
        .i_rstn(rstn), .i_reg_wr(wr), .i_reg_addr(addr), .i_reg_wdata(wdata),
        .i_global_lock(lock), .i_pwm_freq_sel(fsel), .i_peci_temp(ptemp), .i_peci_valid(pval),
        .i_minimum_duty(mind), .i_max_duty(maxd), .o_reg_rdata(rdata), .o_duty(duty));
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    // expected ramp step per code, the same for both frequency selects
    function automatic logic [7:0] step_of(input logic [2:0] c);
        logic [7:0] tbl [8] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h08, 8'h0C, 8'h18, 8'h30};
        return tbl[c];
    endfunction
    // expected duty: minimum at or below threshold, linear over the span, capped
    function automatic logic [7:0] want(input logic [7:0] t, input logic [3:0] sp);
        int d, v;
        d = $signed(t) - $signed(thr);
        v = (d <= 0) ? 0 : ((255 - mind) * d * gn[sp]) >> 12;
        v = (v >= 255 - mind) ? 255 : mind + v;
        return (v > maxd) ? maxd : v[7:0];
    endfunction
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        if (got !== exp) error_cnt++;
    endtask
    task automatic wrr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        addr = a;
        wdata = d;
        wr = 1;
        @(negedge clk);
        wr = 0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(negedge clk);
        addr = a;
        @(negedge clk);
        chk(rdata, exp);
    endtask
    task automatic stop_test;
        $display("compares %0d, mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    initial begin
        repeat (8) @(negedge clk);
        addr = 8'h3C; // first edge after release reads the span register
        rstn = 1;
        chk(duty, 8'hFF);
        rd(8'h3B, 8'hE0);
        rd(8'h3C, 8'hC0);
        rd(8'h3D, 8'h00);
        $display("reset test done");
        // every span code, random threshold, reading and minimum duty
        for (int i = 0; i < 16; i++) begin
            rnd = lfsr(rnd);
            thr = rnd >> 2;
            mind = lfsr(rnd) >> 1;
            maxd = (i == 9) ? 8'h60 : 8'hFF;
            tmp = (i == 3) ? thr : thr + rnd[5:0] - 8'h04;
            wrr(8'h3B, thr);
            wrr(8'h3C, {i[3:0], 4'h0});
            rd(8'h3B, thr);
            u_peci.send(tmp);
            chk(duty, want(tmp, i[3:0]));
        end
        $display("curve test done");
        {maxd, mind} = 16'hFF00;
        wrr(8'h3B, 8'h00);
        // each ramp code from zero toward full; a stuck wait shows as a mismatch
        for (int c = 0; c < 8; c++) begin
            fsel = c[0];
            wrr(8'h3C, 8'hC0);
            u_peci.send(8'h80);
            wrr(8'h3C, {5'h19, c[2:0]});
            u_peci.send(8'h20);
            for (n = 0; n < 40 && duty === 8'h00; n++) @(negedge clk);
            chk(duty, step_of(c[2:0]));
            // a fresh reading: next step lands exactly one round-robin period later
            u_peci.send(8'h20);
            for (n = 2; n < 40 && duty === step_of(c[2:0]); n++) @(negedge clk);
            chk(8'(n), fsel ? 8'h1C : 8'h14);
            chk(duty, 8'(2 * step_of(c[2:0])));
        end
        $display("ramp test done");
        lock = 1;
        wrr(8'h3B, 8'h11);
        wrr(8'h3C, 8'h22);
        rd(8'h3B, 8'h00);
        rd(8'h3C, 8'hCF);
        $display("lock test done");
        stop_test();
    end
endmodule
